//--- include/cc_pkg.sv
/*
  Shared constants and carriers for the control and indirect-access decoder.
  Assumes a 14-bit instruction word and a 16-bit data address space.
*/
`default_nettype none
package cc_pkg;

  // Word and address widths
  localparam int OP_W = 14;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FILE_W = 7;
  localparam int LIT6_W = 6;

  // Exact opcodes
  localparam logic [13:0] OP_BRANCH_ACC = 14'h000b;
  localparam logic [13:0] OP_CALL_ACC = 14'h000a;
  localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_DOG_RESTART = 14'h0064;
  localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
  localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OP_STANDBY = 14'h0063;

  // Opcode families: value and mask
  localparam logic [13:0] OP_DIR_LOAD = 14'h0060;
  localparam logic [13:0] MASK_DIR_LOAD = 14'h3ff8;
  localparam logic [13:0] OP_RET_LIT = 14'h3400;
  localparam logic [13:0] OP_AND_LIT = 14'h3900;
  localparam logic [13:0] OP_ADD_LIT = 14'h3e00;
  localparam logic [13:0] OP_AND_REG = 14'h0500;
  localparam logic [13:0] MASK_BYTE_LIT = 14'h3f00;
  localparam logic [13:0] OP_PTR_ADD = 14'h3100;
  localparam logic [13:0] OP_LOAD_IDX = 14'h3f00;
  localparam logic [13:0] OP_STORE_IDX = 14'h3f80;
  localparam logic [13:0] MASK_IDX = 14'h3f80;
  localparam logic [13:0] OP_LOAD_MOD = 14'h0010;
  localparam logic [13:0] OP_STORE_MOD = 14'h0018;
  localparam logic [13:0] MASK_MOD = 14'h3ff8;

  // Field positions
  localparam int N_MOD_BIT = 2;
  localparam int N_IDX_BIT = 6;
  localparam int DEST_BIT = 7;
  localparam int PTR_TOP_BIT = 15;
  localparam int NIB_W = 4;

  // Indirect window register file addresses
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;

  // Pointer modify modes, mm order matches the two-bit field
  typedef enum logic [2:0] {
    CC_PM_PREINC,
    CC_PM_PREDEC,
    CC_PM_POSTINC,
    CC_PM_POSTDEC,
    CC_PM_ADD,
    CC_PM_INDEX
  } cc_pmode_e;

  // Data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cc_mem_req_s;

  // File register request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cc_file_req_s;

  // Arithmetic status flags
  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } cc_flags_s;

endpackage
`default_nettype wire

//--- logic/cc_ctrl.sv
/*
  Control-transfer, inherent and indirect-pointer instruction execution.
  Assumes same-cycle combinational read data from memory and file register,
  an external return stack, and a fetch unit that follows pc_load.
*/
// Behaviour
// - PC-changing instructions take two cycles; second cycle is a no-operation.
// - Indirect window access with pointer top bit set adds one cycle.
// - Branch-by-accumulator jumps to PC plus one plus W, two cycles.
// - Call-by-accumulator pushes return address, jumps to W target, two cycles.
// - Interrupt return pops address and resumes, two cycles.
// - Return pops address and resumes caller, two cycles.
// - Return-with-literal loads W with literal and returns, two cycles.
// - Dog restart clears watchdog in one cycle, sets timeout and powerdown flags.
// - Option load copies W into prescaler configuration in one cycle.
// - Soft reset opcode requests a whole-device reset.
// - Standby opcode enters standby, sets timeout flag, clears powerdown flag.
// - Direction load copies W into selected direction register in one cycle.
// - Pointer add adds signed 6-bit literal to pointer, flags untouched.
// - Pointer arithmetic wraps modulo 16 bits.
// - Indirect load moves pointed byte to W with modify, updates zero.
// - Indexed load reads pointer plus index into W, updates zero.
// - Indirect store writes W at pointer with modify, flags unchanged.
// - Indexed store writes W at pointer plus index, flags unchanged.
// - Immediate AND writes W and literal into W, updates zero only.
// - Immediate add writes sum into W, updates carry, digit-carry, zero.
// - Register AND writes to W or f by d, updates zero.
`default_nettype none
module cc_ctrl
  import cc_pkg::*;
#(
  parameter int PC_W = 15,
  parameter int DIR_N = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [PC_W-1:0] instr_pc,
  output logic instr_ready,
  // Program counter control
  input wire logic [6:0] pc_high_latch,
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  // Return stack
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  output logic stack_pop,
  input wire logic [PC_W-1:0] stack_top,
  // Data memory and file register
  output cc_mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  output cc_file_req_s file_req,
  input wire logic [7:0] file_rdata,
  // Core state
  output logic [7:0] accumulator,
  output cc_flags_s flags,
  output logic [15:0] indirect_pointer_0,
  output logic [15:0] indirect_pointer_1,
  output logic [7:0] option_reg,
  output logic [DIR_N-1:0][7:0] port_direction_reg,
  // Power and system control
  input wire logic wake,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic dog_restart,
  output logic standby,
  output logic soft_reset,
  output logic irq_enable_set
);

  typedef enum logic [1:0] {CC_ST_RUN, CC_ST_FLUSH, CC_ST_IND} cc_state_e;

  cc_state_e state_q, state_d;
  logic [13:0] ir_q, ir_d;
  logic [PC_W-1:0] ipc_q, ipc_d;
  logic [7:0] acc_q, acc_d;
  cc_flags_s flags_q, flags_d;
  logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
  logic [7:0] option_q, option_d;
  logic [DIR_N-1:0][7:0] dir_q, dir_d;
  logic to_q, to_d, pd_q, pd_d;
  logic standby_q, standby_d;
  logic pc_load_q, pc_load_d;
  logic [PC_W-1:0] pc_target_q, pc_target_d;
  logic dog_q, dog_d, srst_q, srst_d, irqen_q, irqen_d;

  logic take;
  logic [13:0] op;
  logic [PC_W-1:0] op_pc;
  logic is_mod, is_load_mod, is_store_mod, is_idx, is_load_idx, is_store_idx;
  logic is_ptr_add, is_and_reg, win_ref, sel_n;
  logic [15:0] sel_ptr, pm_addr, pm_next;
  cc_pmode_e pm_mode;
  logic needs_extra, exec;
  logic [8:0] add_sum;
  logic [4:0] add_low;
  logic [7:0] and_res;

  // Handshake: no new instruction while flushing, in the extra cycle or in standby
  assign instr_ready = (state_q == CC_ST_RUN) && !standby_q;
  assign take = instr_valid && instr_ready;
  assign op = (state_q == CC_ST_IND) ? ir_q : instr;
  assign op_pc = (state_q == CC_ST_IND) ? ipc_q : instr_pc;

  // Family decode
  assign is_load_mod = (op & MASK_MOD) == OP_LOAD_MOD;
  assign is_store_mod = (op & MASK_MOD) == OP_STORE_MOD;
  assign is_mod = is_load_mod || is_store_mod;
  assign is_load_idx = (op & MASK_IDX) == OP_LOAD_IDX;
  assign is_store_idx = (op & MASK_IDX) == OP_STORE_IDX;
  assign is_idx = is_load_idx || is_store_idx;
  assign is_ptr_add = (op & MASK_IDX) == OP_PTR_ADD;
  assign is_and_reg = (op & MASK_BYTE_LIT) == OP_AND_REG;
  assign win_ref = is_and_reg &&
                   (op[FILE_W-1:0] == WIN0_ADDR || op[FILE_W-1:0] == WIN1_ADDR);

  // Pointer select and modify mode
  always_comb begin
    sel_n = op[N_IDX_BIT];
    pm_mode = CC_PM_INDEX;
    if (is_mod) begin
      sel_n = op[N_MOD_BIT];
      pm_mode = cc_pmode_e'({1'b0, op[1:0]});
    end else if (is_ptr_add) begin
      pm_mode = CC_PM_ADD;
    end else if (win_ref) begin
      sel_n = op[0];
    end
  end

  assign sel_ptr = sel_n ? ptr1_q : ptr0_q;

  cc_ptr_mod u_ptr_mod (
    .ptr(sel_ptr),
    .mode(pm_mode),
    .lit(win_ref ? 6'h00 : op[LIT6_W-1:0]),
    .addr(pm_addr),
    .ptr_next(pm_next)
  );

  // Window accesses with the pointer top bit set take one more cycle
  assign needs_extra = (is_mod || is_idx || win_ref) && sel_ptr[PTR_TOP_BIT];
  assign exec = (take && !needs_extra) || (state_q == CC_ST_IND);

  // Arithmetic for literal and register logic
  assign add_sum = {1'b0, acc_q} + {1'b0, op[7:0]};
  assign add_low = {1'b0, acc_q[NIB_W-1:0]} + {1'b0, op[NIB_W-1:0]};
  assign and_res = acc_q & (win_ref ? mem_rdata : file_rdata);

  // Execute: next values of all architectural state and side requests
  always_comb begin
    state_d = CC_ST_RUN;
    ir_d = ir_q;
    ipc_d = ipc_q;
    acc_d = acc_q;
    flags_d = flags_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    option_d = option_q;
    dir_d = dir_q;
    to_d = to_q;
    pd_d = pd_q;
    standby_d = standby_q && !wake;
    pc_load_d = 1'b0;
    pc_target_d = pc_target_q;
    dog_d = 1'b0;
    srst_d = 1'b0;
    irqen_d = 1'b0;
    stack_push = 1'b0;
    stack_push_data = op_pc + PC_W'(1);
    stack_pop = 1'b0;
    mem_req = '0;
    file_req = '0;
    if (take && needs_extra) begin
      state_d = CC_ST_IND;
      ir_d = instr;
      ipc_d = instr_pc;
    end else if (exec) begin
      if (op == OP_BRANCH_ACC) begin
        pc_load_d = 1'b1;
        pc_target_d = op_pc + PC_W'(1) + PC_W'(acc_q);
        state_d = CC_ST_FLUSH;
      end else if (op == OP_CALL_ACC) begin
        stack_push = 1'b1;
        pc_load_d = 1'b1;
        pc_target_d = PC_W'({pc_high_latch, acc_q});
        state_d = CC_ST_FLUSH;
      end else if (op == OP_IRQ_RETURN) begin
        stack_pop = 1'b1;
        irqen_d = 1'b1;
        pc_load_d = 1'b1;
        pc_target_d = stack_top;
        state_d = CC_ST_FLUSH;
      end else if (op == OP_RETURN) begin
        stack_pop = 1'b1;
        pc_load_d = 1'b1;
        pc_target_d = stack_top;
        state_d = CC_ST_FLUSH;
      end else if ((op & MASK_BYTE_LIT) == OP_RET_LIT) begin
        acc_d = op[7:0];
        stack_pop = 1'b1;
        pc_load_d = 1'b1;
        pc_target_d = stack_top;
        state_d = CC_ST_FLUSH;
      end else if (op == OP_DOG_RESTART) begin
        dog_d = 1'b1;
        to_d = 1'b1;
        pd_d = 1'b1;
      end else if (op == OP_OPTION_LOAD) begin
        option_d = acc_q;
      end else if (op == OP_SOFT_RESET) begin
        srst_d = 1'b1;
      end else if (op == OP_STANDBY) begin
        standby_d = 1'b1;
        dog_d = 1'b1;
        to_d = 1'b1;
        pd_d = 1'b0;
      end else if ((op & MASK_DIR_LOAD) == OP_DIR_LOAD) begin
        dir_d[op[2:0]] = acc_q;
      end else if (is_ptr_add) begin
        if (sel_n) begin
          ptr1_d = pm_next;
        end else begin
          ptr0_d = pm_next;
        end
      end else if (is_load_mod || is_load_idx) begin
        mem_req.rd = 1'b1;
        mem_req.addr = pm_addr;
        acc_d = mem_rdata;
        flags_d.z = (mem_rdata == 8'h00);
        if (is_load_mod && sel_n) begin
          ptr1_d = pm_next;
        end else if (is_load_mod) begin
          ptr0_d = pm_next;
        end
      end else if (is_store_mod || is_store_idx) begin
        mem_req.wr = 1'b1;
        mem_req.addr = pm_addr;
        mem_req.wdata = acc_q;
        if (is_store_mod && sel_n) begin
          ptr1_d = pm_next;
        end else if (is_store_mod) begin
          ptr0_d = pm_next;
        end
      end else if ((op & MASK_BYTE_LIT) == OP_AND_LIT) begin
        acc_d = acc_q & op[7:0];
        flags_d.z = ((acc_q & op[7:0]) == 8'h00);
      end else if ((op & MASK_BYTE_LIT) == OP_ADD_LIT) begin
        acc_d = add_sum[7:0];
        flags_d.c = add_sum[DATA_W];
        flags_d.dc = add_low[NIB_W];
        flags_d.z = (add_sum[7:0] == 8'h00);
      end else if (is_and_reg) begin
        if (win_ref) begin
          mem_req.rd = 1'b1;
          mem_req.addr = pm_addr;
        end else begin
          file_req.rd = 1'b1;
          file_req.addr = op[FILE_W-1:0];
        end
        flags_d.z = (and_res == 8'h00);
        if (!op[DEST_BIT]) begin
          acc_d = and_res;
        end else if (win_ref) begin
          mem_req.wr = 1'b1;
          mem_req.wdata = and_res;
        end else begin
          file_req.wr = 1'b1;
          file_req.wdata = and_res;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= CC_ST_RUN;
      ir_q <= '0;
      ipc_q <= '0;
      acc_q <= ACC_RST;
      flags_q <= '0;
      ptr0_q <= PTR_RST;
      ptr1_q <= PTR_RST;
      option_q <= OPTION_RST;
      dir_q <= {DIR_N{DIR_RST}};
      to_q <= 1'b1;
      pd_q <= 1'b1;
      standby_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_target_q <= '0;
      dog_q <= 1'b0;
      srst_q <= 1'b0;
      irqen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      ipc_q <= ipc_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      option_q <= option_d;
      dir_q <= dir_d;
      to_q <= to_d;
      pd_q <= pd_d;
      standby_q <= standby_d;
      pc_load_q <= pc_load_d;
      pc_target_q <= pc_target_d;
      dog_q <= dog_d;
      srst_q <= srst_d;
      irqen_q <= irqen_d;
    end
  end

  // Registered outputs
  assign pc_load = pc_load_q;
  assign pc_target = pc_target_q;
  assign accumulator = acc_q;
  assign flags = flags_q;
  assign indirect_pointer_0 = ptr0_q;
  assign indirect_pointer_1 = ptr1_q;
  assign option_reg = option_q;
  assign port_direction_reg = dir_q;
  assign timeout_flag = to_q;
  assign powerdown_flag = pd_q;
  assign dog_restart = dog_q;
  assign standby = standby_q;
  assign soft_reset = srst_q;
  assign irq_enable_set = irqen_q;

endmodule
`default_nettype wire

//--- logic/cc_ptr_mod.sv
/*
  Pointer modify unit: access address and next pointer value.
  Assumes the caller picks the pointer and the mode; purely combinational.
*/
`default_nettype none
module cc_ptr_mod
  import cc_pkg::*;
(
  // Operands
  input wire logic [15:0] ptr,
  input wire cc_pmode_e mode,
  input wire logic [5:0] lit,
  // Results
  output logic [15:0] addr,
  output logic [15:0] ptr_next
);

  logic [15:0] lit_ext;
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] sum;

  // 16-bit sums wrap at both ends of the range
  assign lit_ext = {{(ADDR_W - LIT6_W){lit[LIT6_W - 1]}}, lit};
  assign inc = ptr + 16'h0001;
  assign dec = ptr - 16'h0001;
  assign sum = ptr + lit_ext;

  // Mode select
  always_comb begin
    addr = ptr;
    ptr_next = ptr;
    case (mode)
      CC_PM_PREINC: begin
        addr = inc;
        ptr_next = inc;
      end
      CC_PM_PREDEC: begin
        addr = dec;
        ptr_next = dec;
      end
      CC_PM_POSTINC: ptr_next = inc;
      CC_PM_POSTDEC: ptr_next = dec;
      CC_PM_ADD: ptr_next = sum;
      CC_PM_INDEX: addr = sum;
      default: ptr_next = ptr;
    endcase
  end

endmodule
`default_nettype wire

//--- test/cc_ctrl_monitor.sv
/*
  Port-level checks of the control and indirect-access decoder.
  Assumes it is bound into cc_ctrl, one clock, synchronous reset.
*/
`default_nettype none
module cc_ctrl_monitor
  import cc_pkg::*;
#(
  parameter int PC_W = 15
) (
  // Clock, reset and instruction stream
  input wire logic clock,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [PC_W-1:0] instr_pc,
  input wire logic instr_ready,
  // Program flow
  input wire logic [6:0] pc_high_latch,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic [PC_W-1:0] stack_top,
  // Core state and system control
  input wire logic [7:0] accumulator,
  input wire cc_flags_s flags,
  input wire logic [15:0] indirect_pointer_0,
  input wire logic [7:0] option_reg,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic dog_restart,
  input wire logic standby,
  input wire logic soft_reset,
  input wire logic irq_enable_set
);
  logic [PC_W-1:0] br_tgt;
  logic [15:0] k_ext;
  logic [7:0] lit8;
  // Operands seen in the taking cycle
  assign br_tgt = instr_pc + PC_W'(accumulator) + PC_W'(1);
  assign k_ext = {{10{instr[5]}}, instr[5:0]};
  assign lit8 = instr[7:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Instruction accepted at this edge
  sequence s_take(logic [13:0] op, logic [13:0] m);
    instr_valid && instr_ready && (instr & m) == op;
  endsequence
  // Jump issued with the flush cycle refused
  sequence s_jump;
    pc_load && !instr_ready;
  endsequence

  a_branch_rel: assert property (s_take(OP_BRANCH_ACC, 14'h3fff) |=>
    s_jump ##0 pc_target == $past(br_tgt)) else $error("branch target wrong");
  a_call_acc: assert property (s_take(OP_CALL_ACC, 14'h3fff) |->
    stack_push && stack_push_data == instr_pc + PC_W'(1) ##1 s_jump ##0
    pc_target == {$past(pc_high_latch), $past(accumulator)}) else $error("call wrong");
  a_irq_return: assert property (s_take(OP_IRQ_RETURN, 14'h3fff) |-> stack_pop ##1
    s_jump ##0 irq_enable_set && pc_target == $past(stack_top)) else $error("irq ret");
  a_sub_return: assert property (s_take(OP_RETURN, 14'h3fff) |-> stack_pop ##1
    s_jump ##0 pc_target == $past(stack_top)) else $error("return wrong");
  a_lit_return: assert property (s_take(OP_RET_LIT, MASK_BYTE_LIT) |-> stack_pop ##1
    s_jump ##0 accumulator == $past(lit8)) else $error("literal return");
  a_dog_flags: assert property (s_take(OP_DOG_RESTART, 14'h3fff) |=>
    dog_restart && timeout_flag && powerdown_flag) else $error("dog restart");
  a_option_copy: assert property (s_take(OP_OPTION_LOAD, 14'h3fff) |=>
    option_reg == $past(accumulator)) else $error("option load");
  a_soft_pulse: assert property (s_take(OP_SOFT_RESET, 14'h3fff) |=>
    soft_reset ##1 !soft_reset) else $error("soft reset pulse");
  a_standby_entry: assert property (s_take(OP_STANDBY, 14'h3fff) |=>
    standby && !instr_ready && timeout_flag && !powerdown_flag) else $error("standby");
  a_ptr_add: assert property (s_take(OP_PTR_ADD, 14'h3fc0) |=> $stable(flags) &&
    indirect_pointer_0 == $past(indirect_pointer_0) + $past(k_ext))
    else $error("pointer add");
  a_and_lit: assert property (s_take(OP_AND_LIT, MASK_BYTE_LIT) |=>
    accumulator == ($past(accumulator) & $past(lit8)) && flags.c == $past(flags.c) &&
    flags.z == (accumulator == 8'h00)) else $error("and literal");
endmodule

bind cc_ctrl cc_ctrl_monitor #(.PC_W(PC_W)) mon_u (
  .clock(clock), .reset(reset), .instr_valid(instr_valid), .instr(instr),
  .instr_pc(instr_pc), .instr_ready(instr_ready), .pc_high_latch(pc_high_latch),
  .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
  .stack_push_data(stack_push_data), .stack_pop(stack_pop), .stack_top(stack_top),
  .accumulator(accumulator), .flags(flags), .indirect_pointer_0(indirect_pointer_0),
  .option_reg(option_reg), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
  .dog_restart(dog_restart), .standby(standby), .soft_reset(soft_reset),
  .irq_enable_set(irq_enable_set)
);
`default_nettype wire

//--- test/cc_ctrl_tb_top.sv
/*
  Self-checking bench for the control decoder.
  Assumes the bench stands in for fetch, stack, data memory and file register.
*/
`default_nettype none
module cc_ctrl_tb_top
  import cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic wake = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [14:0] instr_pc = 15'h0000;
  logic [14:0] stack_top = 15'h0000;
  logic [6:0] pc_high_latch = 7'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic instr_ready, pc_load, stack_push, stack_pop, timeout_flag, powerdown_flag;
  logic dog_restart, standby, soft_reset, irq_enable_set;
  logic [14:0] pc_target, stack_push_data, pc_v, sk_v, tg;
  cc_mem_req_s mem_req, m_q;
  cc_file_req_s file_req, f_q;
  logic [7:0] accumulator, option_reg, acc_m, rd_v, fd_v, k, r;
  cc_flags_s flags, fl_m;
  logic [15:0] indirect_pointer_0, indirect_pointer_1, p, nx, ae;
  logic [15:0] p_m [2];
  logic [7:0][7:0] port_direction_reg;
  logic [6:0] hl_v, f;
  logic [5:0] k6;
  logic [1:0] mm;
  logic [13:0] op;
  logic n, wr, x, ad;
  int err_count, compares, st, sr_n;
  integer seed = 32'h4e2d;

  cc_ctrl dut_u (
    .clock(clock), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .instr_pc(instr_pc), .instr_ready(instr_ready), .pc_high_latch(pc_high_latch),
    .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .stack_pop(stack_pop), .stack_top(stack_top),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .file_req(file_req), .file_rdata(file_rdata),
    .accumulator(accumulator), .flags(flags), .indirect_pointer_0(indirect_pointer_0),
    .indirect_pointer_1(indirect_pointer_1), .option_reg(option_reg),
    .port_direction_reg(port_direction_reg), .wake(wake), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .dog_restart(dog_restart), .standby(standby),
    .soft_reset(soft_reset), .irq_enable_set(irq_enable_set)
  );

  // Core clock, 25 ns period
  always #12.5 clock = ~clock;

  // Latch requests and count reset pulses where outputs are settled
  always @(negedge clock) begin
    if (mem_req.rd || mem_req.wr) m_q = mem_req;
    if (file_req.rd || file_req.wr) f_q = file_req;
    if (soft_reset === 1'b1) sr_n++;
  end

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Accumulator and flags expected after a literal add or AND
  function automatic logic [10:0] lit_model(input logic [7:0] a, input cc_flags_s fi,
      input logic [7:0] kk, input logic add);
    logic [8:0] s9;
    cc_flags_s fo;
    s9 = {1'b0, a} + {1'b0, kk};
    fo = fi;
    if (add) begin
      fo.c = s9[8];
      fo.dc = 5'(a[3:0]) + 5'(kk[3:0]) > 5'h0f;
    end else begin
      s9[7:0] = a & kk;
    end
    fo.z = s9[7:0] == 8'h00;
    return {s9[7:0], fo};
  endfunction

  // One instruction then a filler; st counts refused cycles of the filler
  task automatic exec(input logic [13:0] o);
    @(posedge clock);
    rd_v = 8'($random(seed));
    fd_v = 8'($random(seed));
    pc_v = 15'($random(seed));
    sk_v = 15'($random(seed));
    hl_v = 7'($random(seed));
    mem_rdata <= rd_v;
    file_rdata <= fd_v;
    instr_pc <= pc_v;
    stack_top <= sk_v;
    pc_high_latch <= hl_v;
    for (int j = 0; j < 2; j++) begin
      st = 0;
      instr <= j ? 14'h0000 : o;
      instr_valid <= 1'b1;
      @(negedge clock);
      while (instr_ready !== 1'b1 && st < 9) begin
        st++;
        @(negedge clock);
      end
      @(posedge clock);
    end
    instr_valid <= 1'b0;
    @(negedge clock);
  endtask

  // Cut a hung run short; the sequence needs well under 40 us
  initial begin
    #200us;
    err_count++;
    test_done();
  end

  initial begin
    acc_m = 8'h00;
    fl_m = '0;
    p_m = '{16'h0000, 16'h0000};
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("rst", {option_reg, port_direction_reg[3], timeout_flag, powerdown_flag, standby,
      indirect_pointer_1}, {16'hffff, 3'b110, 16'h0000});
    // Literal arithmetic, first adds reach all-ones then carry out to zero
    for (int i = 0; i < 24; i++) begin
      k = i < 2 ? 8'hff >> (7 * i) : 8'($random(seed));
      ad = i < 2 || 1'($random(seed));
      exec((ad ? OP_ADD_LIT : OP_AND_LIT) | 14'(k));
      {acc_m, fl_m} = lit_model(acc_m, fl_m, k, ad);
      chk("lit", {accumulator, flags, 8'(st)}, {acc_m, fl_m, 8'h00});
    end
    // Pointer add; pointer 1 wraps below zero, pointer 0 drifts
    for (int i = 0; i < 12; i++) begin
      n = i == 0;
      k6 = n ? 6'h3f : 6'($random(seed));
      exec(OP_PTR_ADD | 14'({n, k6}));
      p_m[n] = p_m[n] + {{10{k6[5]}}, k6};
      chk("ptr_add", {indirect_pointer_1, indirect_pointer_0, flags},
        {p_m[1], p_m[0], fl_m});
    end
    // Modify forms, every mm for both pointers, then indexed forms
    for (int i = 0; i < 24; i++) begin
      x = i >= 16;
      n = i[2];
      mm = i[1:0];
      wr = x ? i[0] : i[3];
      k6 = {1'b0, 5'($random(seed))};
      p = p_m[n];
      nx = mm[0] ? p - 16'h0001 : p + 16'h0001;
      ae = x ? p + 16'(k6) : (mm[1] ? p : nx);
      op = x ? ((wr ? OP_STORE_IDX : OP_LOAD_IDX) | 14'({n, k6}))
        : ((wr ? OP_STORE_MOD : OP_LOAD_MOD) | 14'(i[2:0]));
      exec(op);
      if (!x) p_m[n] = nx;
      if (!wr) acc_m = rd_v;
      if (!wr) fl_m.z = rd_v == 8'h00;
      chk("ind_req", {m_q.rd, m_q.wr, m_q.addr}, {!wr, wr, ae});
      if (wr) chk("ind_wd", m_q.wdata, acc_m);
      chk("ind_st", {accumulator, flags, n ? indirect_pointer_1 : indirect_pointer_0},
        {acc_m, fl_m, p_m[n]});
      chk("ind_cyc", st, p[15]);
    end
    // Register AND to either destination; the last two go through the window registers
    for (int i = 0; i < 10; i++) begin
      ad = i >= 8;
      f = ad ? 7'(i[0]) : 7'h02 + 7'(i * 13);
      exec(OP_AND_REG | 14'({i[0], f}));
      r = acc_m & (ad ? rd_v : fd_v);
      if (!i[0]) acc_m = r;
      fl_m.z = r == 8'h00;
      if (ad) begin
        p = p_m[i[0]];
        chk("and_win", {accumulator, flags, m_q.rd, m_q.wr, m_q.addr},
          {acc_m, fl_m, 1'b1, i[0], p});
        chk("win_cyc", st, p[15]);
      end else begin
      chk("and_reg", {accumulator, flags, f_q.addr, f_q.wr}, {acc_m, fl_m, f, i[0]});
      end
      if (i[0]) chk("and_wd", ad ? m_q.wdata : f_q.wdata, r);
    end
    // Return, interrupt return, call, branch, literal return
    for (int i = 0; i < 5; i++) begin
      k = 8'($random(seed));
      exec(i == 4 ? OP_RET_LIT | 14'(k) : OP_RETURN + 14'(i));
      tg = i == 2 ? {hl_v, acc_m} : (i == 3 ? pc_v + 15'h0001 + 15'(acc_m) : sk_v);
      if (i == 4) acc_m = k;
      chk("flow", {pc_target, accumulator, 8'(st)}, {tg, acc_m, 8'h01});
    end
    // Option and direction loads from fresh accumulator values
    exec(OP_OPTION_LOAD);
    chk("option", option_reg, acc_m);
    for (int s = 0; s < 8; s++) begin
      if (s < 2 || s > 4) begin
        k = 8'($random(seed));
        exec(OP_RET_LIT | 14'(k));
        exec(OP_DIR_LOAD | 14'(s));
        chk("dir", port_direction_reg[s], k);
      end
    end
    // Standby refuses until wake, then restart and soft reset
    exec(OP_STANDBY);
    chk("standby", {standby, instr_ready, timeout_flag, powerdown_flag, 8'(st)},
      {4'b1010, 8'h09});
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    repeat (2) @(negedge clock);
    chk("wake", {standby, instr_ready}, 2'b01);
    exec(OP_DOG_RESTART);
    chk("restart", {timeout_flag, powerdown_flag, 8'(st)}, {2'b11, 8'h00});
    exec(OP_SOFT_RESET);
    chk("soft_rst", sr_n, 1);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("post_rst", {accumulator, indirect_pointer_1}, 24'h000000);
    test_done();
  end
endmodule
`default_nettype wire
